// ===== inc/pcrc_defs.svh
// Register offsets, field positions, reset values and counts for the CRC block
`ifndef PCRC_DEFS_SVH
`define PCRC_DEFS_SVH
`define PCRC_OFF_CON1 8'h00
`define PCRC_OFF_CON2 8'h04
`define PCRC_OFF_XORL 8'h08
`define PCRC_OFF_XORH 8'h0C
`define PCRC_OFF_DIN 8'h10
`define PCRC_OFF_RES 8'h14
`define PCRC_OFF_IST 8'h18
`define PCRC_OFF_IMSK 8'h1C
`define PCRC_B_EN 15
`define PCRC_B_IDL 13
`define PCRC_B_VW_LO 8
`define PCRC_B_FUL 7
`define PCRC_B_MPT 6
`define PCRC_B_ISEL 5
`define PCRC_B_GO 4
`define PCRC_B_LEND 3
`define PCRC_B_DW_LO 8
`define PCRC_IST_CRC 0
`define PCRC_IST_OVF 1
`define PCRC_RST_CTL 16'h0000
`define PCRC_FIFO_DEPTH 16
`define PCRC_FIFO_DEPTH_WIDE 8
`define PCRC_PLEN_NARROW_MAX 5'h07
`endif

// ===== inc/pcrc_pkg.sv
// Types shared by the CRC block
package pcrc_pkg;
  typedef struct packed {
    logic module_enable;
    logic idle_stop;
    logic interrupt_select;
    logic shifter_start;
    logic lsb_first_select;
  } pcrc_ctl_t;
  typedef enum logic [2:0] {
    PCRC_IDLE = 3'b001,
    PCRC_LOAD = 3'b010,
    PCRC_SHIFT = 3'b100
  } pcrc_state_t;
endpackage

// ===== tb/test_pcrc_top.sv
// Self-checking bench for the AXI4-Lite CRC generator
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_defs.svh"
module test_pcrc_top import pcrc_pkg::*;;
  logic aclk, aresetn, sys_idle, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] v, e;
  int miscompares, checked;

  pcrc_top #(.DEPTH(`PCRC_FIFO_DEPTH)) u_dut (
    .aclk, .aresetn, .sys_idle,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task end_sim;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task timed_out;
    miscompares++;
    $display("unexpected wait: expected answer seen none");
    end_sim;
  endtask

  task chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, ex, got);
    end
  endtask

  // Ready channels stay open; each request waits for its own answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk("bresp", 32'h0, {30'h0, s_axi_bresp});
        break;
      end
    end
    if (n == 100) timed_out;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        chk("rresp", 32'h0, {30'h0, s_axi_rresp});
        break;
      end
    end
    if (n == 100) timed_out;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] ex,
    input string n);
    rd(a, v);
    chk(n, ex, v);
  endtask

  task automatic wait_irq;
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (irq === 1'b1) break;
    end
    if (n == 400) timed_out;
  endtask

  // Serial engine: top bit against data bit, poly with term zero forced
  function automatic logic [31:0] crc_m(input logic [31:0] r,
    input logic [31:0] d, input int w, input int pl, input logic [31:0] p,
    input bit lsb);
    logic fb;
    logic [31:0] m;
    m = (pl == 31) ? 32'hFFFFFFFF : ((32'h1 << (pl + 1)) - 32'h1);
    for (int i = 0; i < w; i++) begin
      fb = r[pl] ^ (lsb ? d[i] : d[w - 1 - i]);
      r = ((r << 1) ^ (fb ? (p | 32'h1) : 32'h0)) & m;
    end
    return r;
  endfunction

  initial begin
    aresetn = 1'b0;
    sys_idle = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    miscompares = 0;
    checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`PCRC_OFF_CON1, 32'h0040, "con1 reset");
    rc(`PCRC_OFF_CON2, 32'h0, "con2 reset");
    rc(`PCRC_OFF_XORL, 32'h0, "xorl reset");
    rc(`PCRC_OFF_XORH, 32'h0, "xorh reset");
    rc(8'h40, 32'h0, "unmapped");
    wr(`PCRC_OFF_XORH, 32'hFFFF);
    rc(`PCRC_OFF_XORH, 32'hFFFF, "xorh rw");
    wr(`PCRC_OFF_XORL, 32'hFFFF);
    rc(`PCRC_OFF_XORL, 32'hFFFE, "xorl rw");
    wr(`PCRC_OFF_CON2, 32'hFFFF);
    rc(`PCRC_OFF_CON2, 32'h1F1F, "con2 rw");
    wr(`PCRC_OFF_CON2, 32'h0707);
    wr(`PCRC_OFF_CON1, 32'h8000);
    for (int i = 0; i < 16; i++) wr(`PCRC_OFF_DIN, i);
    rc(`PCRC_OFF_CON1, 32'h9080, "count narrow");
    wr(`PCRC_OFF_IMSK, 32'h1);
    wr(`PCRC_OFF_DIN, 32'h0);
    rc(`PCRC_OFF_IST, 32'h2, "overflow status");
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(`PCRC_OFF_CON1, 32'h0);
    rc(`PCRC_OFF_CON1, 32'h0040, "disabled con1");
    rc(`PCRC_OFF_CON2, 32'h0707, "kept con2");
    wr(`PCRC_OFF_IST, 32'h3);
    wr(`PCRC_OFF_CON2, 32'h070F);
    wr(`PCRC_OFF_CON1, 32'h8000);
    for (int i = 0; i < 8; i++) wr(`PCRC_OFF_DIN, i);
    rc(`PCRC_OFF_CON1, 32'h8880, "count wide");
    wr(`PCRC_OFF_CON1, 32'h0);
    wr(`PCRC_OFF_XORH, 32'h0);
    wr(`PCRC_OFF_XORL, 32'h1020);
    // Width, endian and interrupt source varied together over four runs
    for (int k = 0; k < 4; k++) begin
      wr(`PCRC_OFF_CON2, {16'h0, 8'(7 - k), 8'h0F});
      wr(`PCRC_OFF_CON1, (k == 3) ? 32'hA000 : 32'h8000);
      wr(`PCRC_OFF_DIN, 32'h31 + k);
      wr(`PCRC_OFF_DIN, 32'hA5);
      sys_idle <= (k == 3);
      v = 32'h8010 | (32'(k[1]) << 5) | (32'(k[0]) << 3);
      if (k == 3) v = v | 32'h2000;
      wr(`PCRC_OFF_CON1, v);
      if (k == 3) begin
        repeat (40) @(posedge aclk);
        chk("irq in idle", 32'h0, {31'h0, irq});
        sys_idle <= 1'b0;
      end
      wait_irq;
      repeat (30) @(posedge aclk);
      e = crc_m(32'h0, 32'h31 + k, 8 - k, 15, 32'h1020, k[0]);
      e = crc_m(e, 32'hA5, 8 - k, 15, 32'h1020, k[0]);
      rc(`PCRC_OFF_RES, e, "result");
      rc(`PCRC_OFF_IST, 32'h1, "event status");
      wr(`PCRC_OFF_IST, 32'h1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(`PCRC_OFF_CON1, 32'h0);
      rc(`PCRC_OFF_RES, 32'h0, "result cleared");
    end
    end_sim;
  end
endmodule
`default_nettype wire

// ===== verilog/pcrc_top.sv
// AXI4-Lite programmable CRC generator with word FIFO and serial engine
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_defs.svh"
module pcrc_top import pcrc_pkg::*; #(
  parameter int DEPTH = `PCRC_FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sys_idle,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  localparam int PW = $clog2(DEPTH);
  pcrc_ctl_t ctl_r;
  logic [4:0] data_width_field_r;
  logic [4:0] poly_length_field_r;
  logic [15:0] poly_hi_r;
  logic [15:1] poly_lo_r;
  logic [31:0] fifo_mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [4:0] valid_word_count;
  logic [4:0] max_words;
  logic fifo_full_flag;
  logic fifo_empty_flag;
  logic [31:0] result_register;
  logic [31:0] shreg_r;
  logic [31:0] word_r;
  logic [4:0] bitcnt_r;
  pcrc_state_t st_r;
  logic [1:0] ist_r;
  logic [1:0] imsk_r;
  logic idle_s1_r;
  logic idle_s2_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic aw_have_r;
  logic w_have_r;
  logic wlanes_ok_r;
  logic [7:0] waddr;
  logic [7:0] raddr;
  logic wr_fire;
  logic wr_ok;
  logic push;
  logic pop;
  logic run;
  logic done_evt;
  logic empty_evt;
  logic ovf_evt;
  logic crc_evt;
  logic [31:0] poly;
  logic [31:0] top_mask;
  logic fb;
  logic [31:0] shnext;
  logic [31:0] rd_nxt;
  // Idle request comes from the power manager domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_s1_r <= 1'b0;
      idle_s2_r <= 1'b0;
    end else begin
      idle_s1_r <= sys_idle;
      idle_s2_r <= idle_s1_r;
    end
  end
  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign waddr = awaddr_r[7:0];
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wlanes_ok_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        // Strobes only qualify the beat they came with
        wlanes_ok_r <= (s_axi_wstrb[1:0] == 2'h3);
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Only the low two byte lanes carry the 16-bit registers
  assign wr_ok = wr_fire && wlanes_ok_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= '0;
      data_width_field_r <= 5'h00;
      poly_length_field_r <= 5'h00;
      poly_hi_r <= `PCRC_RST_CTL;
      poly_lo_r <= 15'h0000;
      imsk_r <= 2'h0;
    end else if (wr_ok) begin
      case (waddr)
        `PCRC_OFF_CON1: begin
          ctl_r.module_enable <= wdata_r[`PCRC_B_EN];
          ctl_r.idle_stop <= wdata_r[`PCRC_B_IDL];
          ctl_r.interrupt_select <= wdata_r[`PCRC_B_ISEL];
          ctl_r.shifter_start <= wdata_r[`PCRC_B_GO];
          ctl_r.lsb_first_select <= wdata_r[`PCRC_B_LEND];
        end
        `PCRC_OFF_CON2: begin
          data_width_field_r <= wdata_r[`PCRC_B_DW_LO +: 5];
          poly_length_field_r <= wdata_r[4:0];
        end
        `PCRC_OFF_XORH: poly_hi_r <= wdata_r[15:0];
        `PCRC_OFF_XORL: poly_lo_r <= wdata_r[15:1];
        `PCRC_OFF_IMSK: imsk_r <= wdata_r[1:0];
        default: begin
        end
      endcase
    end
  end
  // FIFO depth halves for wide polynomials
  assign max_words = (poly_length_field_r > `PCRC_PLEN_NARROW_MAX) ?
    5'(`PCRC_FIFO_DEPTH_WIDE) : 5'(DEPTH);
  // At or above: a length change may shrink the limit under a full FIFO
  assign fifo_full_flag = (valid_word_count >= max_words);
  assign fifo_empty_flag = (valid_word_count == 5'h00);
  // Writes past full are dropped and flagged
  assign push = wr_ok && (waddr == `PCRC_OFF_DIN) && ctl_r.module_enable &&
    !fifo_full_flag;
  assign ovf_evt = wr_ok && (waddr == `PCRC_OFF_DIN) && fifo_full_flag;
  assign run = ctl_r.module_enable && ctl_r.shifter_start &&
    !(ctl_r.idle_stop && idle_s2_r);
  assign pop = run && (st_r == PCRC_IDLE) && !fifo_empty_flag;
  always_ff @(posedge aclk) begin
    if (push) begin
      fifo_mem[wp_r] <= wdata_r;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl_r.module_enable) begin
      wp_r <= '0;
      rp_r <= '0;
      valid_word_count <= 5'h00;
    end else begin
      if (push) begin
        wp_r <= PW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= PW'(rp_r + 1'b1);
      end
      valid_word_count <= 5'(valid_word_count + push - pop);
    end
  end
  // Term zero always applied; top term implied by length
  assign poly = {poly_hi_r, poly_lo_r, 1'b1};
  assign top_mask = 32'hFFFF_FFFF >> (5'h1F - poly_length_field_r);
  // Engine: one data bit per clock, left-shifting register
  always_comb begin
    fb = shreg_r[poly_length_field_r] ^ (ctl_r.lsb_first_select ?
      word_r[bitcnt_r] :
      word_r[data_width_field_r - bitcnt_r]);
    shnext = {shreg_r[30:0], 1'b0};
    if (fb) begin
      shnext = shnext ^ poly;
    end
    shnext = shnext & top_mask;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl_r.module_enable) begin
      st_r <= PCRC_IDLE;
      shreg_r <= 32'h0000_0000;
      bitcnt_r <= 5'h00;
      word_r <= 32'h0000_0000;
      result_register <= 32'h0000_0000;
    end else begin
      case (st_r)
        PCRC_IDLE: begin
          bitcnt_r <= 5'h00;
          if (pop) begin
            // Latched here, since the read pointer moves on at pop
            word_r <= fifo_mem[rp_r];
            st_r <= PCRC_SHIFT;
          end
        end
        PCRC_SHIFT: begin
          if (run) begin
            shreg_r <= shnext;
            bitcnt_r <= 5'(bitcnt_r + 1'b1);
            if (bitcnt_r == data_width_field_r) begin
              st_r <= PCRC_LOAD;
            end
          end else if (!ctl_r.shifter_start) begin
            st_r <= PCRC_IDLE;
          end
        end
        PCRC_LOAD: begin
          result_register <= shreg_r;
          st_r <= PCRC_IDLE;
        end
        default: st_r <= PCRC_IDLE;
      endcase
    end
  end
  // Last word still shifts from its latch once the FIFO reads empty
  assign done_evt = (st_r == PCRC_LOAD) && fifo_empty_flag;
  assign empty_evt = pop && !push && (valid_word_count == 5'h01);
  assign crc_evt = ctl_r.interrupt_select ? empty_evt : done_evt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_r <= 2'h0;
    end else begin
      // Set wins over a same-cycle write-one-to-clear
      for (int i = 0; i < 2; i++) begin
        if ((i == `PCRC_IST_CRC && crc_evt) ||
            (i == `PCRC_IST_OVF && ovf_evt)) begin
          ist_r[i] <= 1'b1;
        end else if (wr_ok && waddr == `PCRC_OFF_IST && wdata_r[i]) begin
          ist_r[i] <= 1'b0;
        end
      end
    end
  end
  assign irq = |(ist_r & imsk_r);
  // Read channel
  assign raddr = s_axi_araddr[7:0];
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (raddr)
      `PCRC_OFF_CON1: begin
        rd_nxt[`PCRC_B_EN] = ctl_r.module_enable;
        rd_nxt[`PCRC_B_IDL] = ctl_r.idle_stop;
        rd_nxt[`PCRC_B_VW_LO +: 5] = valid_word_count;
        rd_nxt[`PCRC_B_FUL] = fifo_full_flag;
        rd_nxt[`PCRC_B_MPT] = fifo_empty_flag;
        rd_nxt[`PCRC_B_ISEL] = ctl_r.interrupt_select;
        rd_nxt[`PCRC_B_GO] = ctl_r.shifter_start;
        rd_nxt[`PCRC_B_LEND] = ctl_r.lsb_first_select;
      end
      `PCRC_OFF_CON2: begin
        rd_nxt[`PCRC_B_DW_LO +: 5] = data_width_field_r;
        rd_nxt[4:0] = poly_length_field_r;
      end
      `PCRC_OFF_XORH: rd_nxt[15:0] = poly_hi_r;
      `PCRC_OFF_XORL: rd_nxt[15:0] = {poly_lo_r, 1'b0};
      `PCRC_OFF_RES: rd_nxt = result_register;
      `PCRC_OFF_IST: rd_nxt[1:0] = ist_r;
      `PCRC_OFF_IMSK: rd_nxt[1:0] = imsk_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_nxt;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  a_full_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (fifo_full_flag && !pop && ctl_r.module_enable) |=>
      valid_word_count == $past(valid_word_count))
    else $error("word count moved while full");
  a_empty_reset: assert property (@(posedge aclk)
    !aresetn |=> fifo_empty_flag)
    else $error("empty flag low after reset");
  a_disable_clears: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !ctl_r.module_enable |=> valid_word_count == 5'h00 &&
      result_register == 32'h0000_0000)
    else $error("disable did not clear state");
  a_count_limit: assert property (@(posedge aclk)
    disable iff (!aresetn)
    push |=> valid_word_count <= max_words)
    else $error("word count above maximum");
  a_idle_halt: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (ctl_r.idle_stop && idle_s2_r && ctl_r.module_enable) |=>
      $stable(shreg_r) && $stable(rp_r))
    else $error("shifter ran in idle");
  a_shift_done: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (st_r == PCRC_SHIFT && run && bitcnt_r == data_width_field_r)
    |=> st_r == PCRC_LOAD)
    else $error("word length not honoured");
  a_low_bit_zero: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_axi_rvalid && $past(raddr) == `PCRC_OFF_XORL &&
    $past(s_axi_arvalid && s_axi_arready) |-> !s_axi_rdata[0])
    else $error("low poly bit 0 read nonzero");
  a_irq_sel: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (crc_evt && imsk_r[0]) |=> irq || !imsk_r[0])
    else $error("interrupt not raised");
  a_top_mask: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (st_r == PCRC_SHIFT && run) |=>
      (shreg_r & ~$past(top_mask)) == 32'h0000_0000)
    else $error("engine bits beyond length");
  c_push: cover property (@(posedge aclk) push);
  c_full: cover property (@(posedge aclk) fifo_full_flag);
  c_done: cover property (@(posedge aclk) done_evt);
  c_irq: cover property (@(posedge aclk) irq);
endmodule
`default_nettype wire
